/* core/sbs_top.sv */
// How it works
// - Brake input high brakes, low runs; CTRL_BRAKE set also brakes with the input low
// - CC brake holds +/-100% by phase sign
// - Step clocks advance angle while braking
// - Brake forces current ratio to full
// - Plus switch positive, minus switch negative
// - No CC plus brake: all four on
// - Home flag low only at initial angle
// - Fault flag low after shutdown detected
// - Fault clears on power or standby
// - Alarm low at detect, auto release below
// - Reference on logic supply disables CC
// - All select inputs low: standby, clears faults
// - Shutdown keeps outputs off until cleared
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module sbs_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // Host control pins
    input wire logic step_clk_i,
    input wire logic dir_i,
    input wire logic brake_hold_i,
    input wire logic [2:0] step_resolution_select_i,
    // Supply and detector comparators
    input wire logic motor_power_supply_i,
    input wire logic cc_disable_i,
    input wire logic thermal_shutdown_i,
    input wire logic overcurrent_shutdown_i,
    input wire logic alarm_detect_i,
    input wire logic alarm_release_i,
    // Open-drain flags
    input wire logic home_angle_flag_i,
    output logic home_angle_flag_o,
    output logic home_angle_flag_oe_o,
    input wire logic fault_flag_i,
    output logic fault_flag_o,
    output logic fault_flag_oe_o,
    input wire logic thermal_alarm_out_i,
    output logic thermal_alarm_out_o,
    output logic thermal_alarm_out_oe_o,
    // Output stage
    output logic phase_a_plus_output_o,
    output logic phase_a_minus_output_o,
    output logic phase_b_plus_output_o,
    output logic phase_b_minus_output_o,
    output logic [sbs_pkg::ANG_W-1:0] angle_o,
    output logic [7:0] ratio_force_o,
    output logic ratio_forced_o
);
    import sbs_pkg::*;

    // Top state and startup counter
    sbs_state_t state;
    sbs_state_t next_state;
    logic [CNT_W-1:0] start_cnt;

    // Edge history for step clock and supply
    logic step_prev;
    logic power_prev;

    // Alarm latch, brake sign memory, edge memory for events
    logic alarm;
    logic brake_prev;
    logic sign_a_held;
    logic sign_b_held;
    logic home_prev;

    // Register side
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] events;
    logic [ST_W-1:0] status;

    // Angle counter outputs
    logic [ANG_W-1:0] angle;
    logic home;

    wire standby = (step_resolution_select_i == MODE_LOW_POWER_STANDBY);
    // Supply reassertion edge
    wire power_rise = motor_power_supply_i && !power_prev;
    wire shutdown = thermal_shutdown_i || overcurrent_shutdown_i;
    // Step edge, only honoured while running or tripped
    wire step_pulse = step_clk_i && !step_prev && (state == SBS_RUN || state == SBS_TRIP);
    wire brake = brake_hold_i || ctrl[CTRL_BRAKE];
    wire brake_rise = brake && !brake_prev;
    wire startup_done = (start_cnt == CNT_W'(STARTUP_CYC - 1));

    // Angle increment from the resolution select
    logic [ANG_W-1:0] inc;
    always_comb begin
        case (step_resolution_select_i)
            MODE_FULL: inc = INC_FULL;
            MODE_HALF_A: inc = INC_HALF;
            MODE_HALF_B: inc = INC_HALF;
            MODE_QUARTER: inc = INC_QUARTER;
            MODE_EIGHTH: inc = INC_EIGHTH;
            MODE_SIXTEENTH: inc = INC_SIXTEENTH;
            default: inc = INC_THIRTYSECOND;
        endcase
    end

    // Phase signs from the angle quadrant
    // sign by conducting switch
    wire sign_a = !angle[ANG_W-1];
    wire sign_b = !(angle[ANG_W-1] ^ angle[ANG_W-2]);

    // Output stage live only when running, powered and enabled
    // off while tripped
    wire stage_on = (state == SBS_RUN) && motor_power_supply_i && ctrl[CTRL_OUT_EN];
    // no regulation when reference on logic supply
    wire cc_on = !cc_disable_i;

    // Switch pattern before the output flops
    logic [3:0] next_sw;
    always_comb begin
        if (!stage_on) begin
            next_sw = 4'h0;
        end else if (brake && !cc_on) begin
            next_sw = 4'hf;
        end else if (brake) begin
            next_sw = {sign_a_held, !sign_a_held, sign_b_held, !sign_b_held};
        end else begin
            next_sw = {sign_a, !sign_a, sign_b, !sign_b};
        end
    end

    // State transitions
    always_comb begin
        next_state = state;
        case (state)
            SBS_STANDBY: begin
                if (!standby) begin
                    next_state = SBS_STARTUP;
                end
            end
            SBS_STARTUP: begin
                if (standby) begin
                    next_state = SBS_STANDBY;
                end else if (shutdown) begin
                    next_state = SBS_TRIP;
                end else if (startup_done) begin
                    next_state = SBS_RUN;
                end
            end
            SBS_RUN: begin
                if (standby) begin
                    next_state = SBS_STANDBY;
                end else if (shutdown) begin
                    next_state = SBS_TRIP;
                end
            end
            SBS_TRIP: begin
                // a fresh shutdown outweighs the clear
                if (shutdown) begin
                    next_state = SBS_TRIP;
                end else if (standby) begin
                    next_state = SBS_STANDBY;
                end else if (power_rise) begin
                    next_state = SBS_RUN;
                end
            end
            default: next_state = SBS_STANDBY;
        endcase
    end

    // State register and startup wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SBS_STANDBY;
            start_cnt <= '0;
        end else begin
            state <= next_state;
            start_cnt <= (state == SBS_STARTUP) ? start_cnt + 1'b1 : '0;
        end
    end

    // Edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_prev <= 1'b0;
            power_prev <= 1'b0;
            brake_prev <= 1'b0;
            // Angle starts at home, so no false home event after reset
            home_prev <= 1'b1;
        end else begin
            step_prev <= step_clk_i;
            power_prev <= motor_power_supply_i;
            brake_prev <= brake;
            home_prev <= home;
        end
    end

    // Phase sign captured at brake entry, tracked otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sign_a_held <= 1'b1;
            sign_b_held <= 1'b1;
        end else if (!brake || brake_rise) begin
            sign_a_held <= sign_a;
            sign_b_held <= sign_b;
        end
    end

    // alarm sets at detect, releases on its own
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm <= 1'b0;
        end else if (alarm_detect_i) begin
            alarm <= 1'b1;
        end else if (alarm_release_i) begin
            alarm <= 1'b0;
        end
    end

    // Registered pins; flags drive low through their enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {phase_a_plus_output_o, phase_a_minus_output_o} <= 2'h0;
            {phase_b_plus_output_o, phase_b_minus_output_o} <= 2'h0;
            home_angle_flag_oe_o <= 1'b0;
            fault_flag_oe_o <= 1'b0;
            thermal_alarm_out_oe_o <= 1'b0;
            angle_o <= ANG_HOME;
            ratio_force_o <= RATIO_ZERO;
            ratio_forced_o <= 1'b0;
        end else begin
            {phase_a_plus_output_o, phase_a_minus_output_o} <= next_sw[3:2];
            {phase_b_plus_output_o, phase_b_minus_output_o} <= next_sw[1:0];
            home_angle_flag_oe_o <= home;
            fault_flag_oe_o <= (next_state == SBS_TRIP);
            thermal_alarm_out_oe_o <= alarm;
            angle_o <= angle;
            ratio_force_o <= brake ? RATIO_FULL : RATIO_ZERO;
            ratio_forced_o <= brake;
        end
    end

    // Open drain outputs only ever pull low
    assign home_angle_flag_o = 1'b0;
    assign fault_flag_o = 1'b0;
    assign thermal_alarm_out_o = 1'b0;

    // Events for the interrupt block
    assign events[IRQ_FAULT] = (state != SBS_TRIP) && (next_state == SBS_TRIP);
    assign events[IRQ_ALM_SET] = alarm_detect_i && !alarm;
    assign events[IRQ_ALM_CLR] = alarm_release_i && !alarm_detect_i && alarm;
    assign events[IRQ_HOME] = home && !home_prev;

    // Status word: angle, latches, mode, pin readback
    assign status = {thermal_alarm_out_i, fault_flag_i, home_angle_flag_i,
                     (state == SBS_STARTUP), brake, standby, home, alarm,
                     (state == SBS_TRIP), 1'b0, angle};

    // Angle counter, cleared in standby
    sbs_angle_ctr u_angle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(state == SBS_STANDBY),
        .step_i(step_pulse),
        .dir_i(dir_i),
        .inc_i(inc),
        .angle_o(angle),
        .home_o(home)
    );

    // Register file and interrupt
    sbs_wb_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .status_i(status),
        .event_i(events),
        .ctrl_o(ctrl),
        .irq_o(irq_o)
    );
endmodule

/* core/sbs_pkg.sv */
package sbs_pkg;
    // Clock and startup quiet time after standby exit
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned STARTUP_US = 10;
    localparam longint unsigned STARTUP_CYC = (STARTUP_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned CNT_W = 10;

    // Electrical angle, 128 positions per electrical turn
    localparam int unsigned ANG_W = 7;
    localparam logic [6:0] ANG_HOME = 7'h00;

    // Angle advance per step clock, by resolution
    localparam logic [6:0] INC_FULL = 7'h20;
    localparam logic [6:0] INC_HALF = 7'h10;
    localparam logic [6:0] INC_QUARTER = 7'h08;
    localparam logic [6:0] INC_EIGHTH = 7'h04;
    localparam logic [6:0] INC_SIXTEENTH = 7'h02;
    localparam logic [6:0] INC_THIRTYSECOND = 7'h01;

    // Step resolution select codes
    localparam logic [2:0] MODE_LOW_POWER_STANDBY = 3'h0;
    localparam logic [2:0] MODE_FULL = 3'h1;
    localparam logic [2:0] MODE_HALF_A = 3'h2;
    localparam logic [2:0] MODE_QUARTER = 3'h3;
    localparam logic [2:0] MODE_HALF_B = 3'h4;
    localparam logic [2:0] MODE_EIGHTH = 3'h5;
    localparam logic [2:0] MODE_SIXTEENTH = 3'h6;

    // Current ratio full scale, percent
    localparam logic [7:0] RATIO_FULL = 8'h64;
    localparam logic [7:0] RATIO_ZERO = 8'h00;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;

    // Control fields
    localparam int unsigned CTRL_W = 2;
    localparam int unsigned CTRL_OUT_EN = 0;
    localparam int unsigned CTRL_BRAKE = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // Interrupt event bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_FAULT = 0;
    localparam int unsigned IRQ_ALM_SET = 1;
    localparam int unsigned IRQ_ALM_CLR = 2;
    localparam int unsigned IRQ_HOME = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // Status fields
    localparam int unsigned ST_W = 17;
    localparam logic [16:0] ST_RESET = 17'h00000;

    // Top state, Gray along standby, startup, run, trip
    typedef enum logic [1:0] {
        SBS_STANDBY = 2'b00,
        SBS_STARTUP = 2'b01,
        SBS_RUN = 2'b11,
        SBS_TRIP = 2'b10
    } sbs_state_t;
endpackage

/* core/sbs_angle_ctr.sv */
`timescale 1ns/1ns
module sbs_angle_ctr (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic [sbs_pkg::ANG_W-1:0] inc_i,
    // Angle state
    output logic [sbs_pkg::ANG_W-1:0] angle_o,
    output logic home_o
);
    import sbs_pkg::*;

    // Next angle, forward or backward by the resolution step
    logic [ANG_W-1:0] next_angle;
    assign next_angle = dir_i ? (angle_o + inc_i) : (angle_o - inc_i);

    // Counter; reset value is the initial angle
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            angle_o <= ANG_HOME;
        end else if (step_i) begin
            angle_o <= next_angle;
        end
    end

    // Home compare from the counter itself
    assign home_o = (angle_o == ANG_HOME);
endmodule

/* core/sbs_wb_regs.sv */
`timescale 1ns/1ns
module sbs_wb_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Block side
    input wire logic [sbs_pkg::ST_W-1:0] status_i,
    input wire logic [sbs_pkg::IRQ_W-1:0] event_i,
    output logic [sbs_pkg::CTRL_W-1:0] ctrl_o,
    output logic irq_o
);
    import sbs_pkg::*;

    // Interrupt status and enable
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;

    // Access decode, one ack per request
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire hit_ctrl = (wb_adr_i == REG_CTRL);
    wire hit_clr = (wb_adr_i == REG_IRQ_CLR);
    wire hit_en = (wb_adr_i == REG_IRQ_EN);
    wire [IRQ_W-1:0] clr_mask = (wr && hit_clr) ? wb_dat_i[IRQ_W-1:0] : '0;

    // Read mux; unmapped and write-only read zero
    logic [31:0] rd_data;
    always_comb begin
        rd_data = '0;
        case (wb_adr_i)
            REG_CTRL: rd_data[CTRL_W-1:0] = ctrl_o;
            REG_STATUS: rd_data[ST_W-1:0] = status_i;
            REG_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat;
            REG_IRQ_EN: rd_data[IRQ_W-1:0] = irq_en;
            default: rd_data = '0;
        endcase
    end

    // Ack and read data one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : '0;
        end
    end

    // Writable registers; low byte lane only carries fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o <= CTRL_RESET;
            irq_en <= IRQ_RESET;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_o <= wb_dat_i[CTRL_W-1:0];
            end
            if (wr && hit_en) begin
                irq_en <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // Sticky events; a set in the clear cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= IRQ_RESET;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~clr_mask) | event_i;
            irq_o <= |(((irq_stat & ~clr_mask) | event_i) & irq_en);
        end
    end
endmodule

/* test/sbs_assertions.sv */
`timescale 1ns/1ns
module sbs_assertions (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Host pins and comparators
    input wire logic brake_hold_i,
    input wire logic [2:0] step_resolution_select_i,
    input wire logic motor_power_supply_i,
    input wire logic cc_disable_i,
    input wire logic thermal_shutdown_i,
    input wire logic overcurrent_shutdown_i,
    input wire logic alarm_detect_i,
    input wire logic alarm_release_i,
    // Flags and output stage
    input wire logic home_angle_flag_oe_o,
    input wire logic fault_flag_oe_o,
    input wire logic thermal_alarm_out_oe_o,
    input wire logic phase_a_plus_output_o,
    input wire logic phase_a_minus_output_o,
    input wire logic phase_b_plus_output_o,
    input wire logic phase_b_minus_output_o,
    input wire logic [6:0] angle_o,
    input wire logic [7:0] ratio_force_o,
    input wire logic ratio_forced_o
);
    // Switch gates, A plus first
    wire logic [3:0] sw = {phase_a_plus_output_o, phase_a_minus_output_o,
        phase_b_plus_output_o, phase_b_minus_output_o};
    // Standby select code
    wire logic low_power_standby = step_resolution_select_i == 3'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ratio_on_brake_a: assert property (
        brake_hold_i |=> ratio_forced_o && ratio_force_o == 8'h64)
        else $error("Brake did not force full ratio");
    ratio_level_a: assert property (
        ratio_force_o == (ratio_forced_o ? 8'h64 : 8'h00))
        else $error("Ratio value disagrees with brake");
    // Reset values still visible one edge after release
    home_flag_a: assert property (
        !$past(rst_i) |-> home_angle_flag_oe_o == (angle_o == 7'h00))
        else $error("Home flag disagrees with angle");
    // Standby and the edge leaving it clear the latch instead
    fault_set_a: assert property (
        (thermal_shutdown_i || overcurrent_shutdown_i) && !low_power_standby && !$past(low_power_standby)
        |=> fault_flag_oe_o)
        else $error("Fault flag not raised");
    // Edge detectors may lag, so quiet history is demanded
    fault_hold_a: assert property (
        fault_flag_oe_o && !low_power_standby && !$past(low_power_standby) && motor_power_supply_i
        && $past(motor_power_supply_i) && $past(motor_power_supply_i, 2) |=> fault_flag_oe_o)
        else $error("Fault flag released early");
    trip_off_a: assert property (
        fault_flag_oe_o && $past(fault_flag_oe_o) |-> sw == 4'h0)
        else $error("Switches on during trip");
    cc_pair_a: assert property (
        phase_a_plus_output_o && phase_a_minus_output_o |-> $past(cc_disable_i))
        else $error("Both A switches on under regulation");
    // Sign must not follow steps taken while braking
    brake_sign_a: assert property (
        $past(brake_hold_i, 3) && $past(brake_hold_i, 2) && $past(brake_hold_i)
        && !$past(cc_disable_i, 2) && !$past(cc_disable_i) && $past(sw) != 4'h0
        && sw != 4'h0 |-> $stable(sw))
        else $error("Brake switch pattern moved");
    // Flag flop follows the alarm latch, so two edges after the input
    alarm_set_a: assert property (
        alarm_detect_i |-> ##2 thermal_alarm_out_oe_o)
        else $error("Alarm flag not raised");
    alarm_clear_a: assert property (
        alarm_release_i && !alarm_detect_i |-> ##2 !thermal_alarm_out_oe_o)
        else $error("Alarm flag not released");
    standby_clear_a: assert property (
        low_power_standby [*4] |-> angle_o == 7'h00 && sw == 4'h0)
        else $error("Standby left angle or switches");
endmodule

/* test/sbs_host_model.sv */
`timescale 1ns/1ns
module sbs_host_model (
    // Clock
    input wire logic clk_i,
    // Host control pins
    output logic step_clk_o,
    output logic dir_o,
    output logic brake_hold_o,
    output logic [2:0] sel_o
);
    import sbs_pkg::*;
    // Startup wait with a small margin
    localparam int QUIET = int'(STARTUP_CYC) + 10;

    // Idle pins, device parked in standby
    initial begin
        step_clk_o = 1'b0;
        dir_o = 1'b0;
        brake_hold_o = 1'b0;
        sel_o = MODE_LOW_POWER_STANDBY;
    end

    // Select a mode; leaving standby costs the startup time
    task automatic mode(input logic [2:0] m);
        @(posedge clk_i);
        if (sel_o == MODE_LOW_POWER_STANDBY && m != MODE_LOW_POWER_STANDBY)
            repeat (QUIET) @(posedge clk_i);
        sel_o <= m;
        if (sel_o == MODE_LOW_POWER_STANDBY && m != MODE_LOW_POWER_STANDBY)
            repeat (QUIET) @(posedge clk_i);
    endtask

    task automatic brake(input logic b);
        @(posedge clk_i);
        brake_hold_o <= b;
    endtask

    // One high and one low cycle per step
    task automatic step(input int n, input logic d);
        repeat (n) begin
            @(posedge clk_i);
            dir_o <= d;
            step_clk_o <= 1'b1;
            @(posedge clk_i);
            step_clk_o <= 1'b0;
        end
    endtask
endmodule

/* test/sbs_top_bench.sv */
`timescale 1ns/1ns
module sbs_top_bench;
    import sbs_pkg::*;
    // Clock, reset and bus
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, irq_o;
    // Host pins, driven by the partner
    logic step_clk_i, dir_i, brake_hold_i;
    logic [2:0] step_resolution_select_i;
    // Supply and comparators
    logic motor_power_supply_i = 1'b1, cc_disable_i = 1'b0;
    logic thermal_shutdown_i = 1'b0, overcurrent_shutdown_i = 1'b0;
    logic alarm_detect_i = 1'b0, alarm_release_i = 1'b0;
    // Flags and output stage
    logic home_angle_flag_o, home_angle_flag_oe_o, fault_flag_o, fault_flag_oe_o;
    logic thermal_alarm_out_o, thermal_alarm_out_oe_o, ratio_forced_o;
    logic phase_a_plus_output_o, phase_a_minus_output_o;
    logic phase_b_plus_output_o, phase_b_minus_output_o;
    logic [6:0] angle_o, exp_ang = 7'h00, sign_ang = 7'h00;
    logic [7:0] ratio_force_o;
    // Pulled-up pins read high unless driven
    wire logic home_angle_flag_i = home_angle_flag_oe_o ? home_angle_flag_o : 1'b1;
    wire logic fault_flag_i = fault_flag_oe_o ? fault_flag_o : 1'b1;
    wire logic thermal_alarm_out_i = thermal_alarm_out_oe_o ? thermal_alarm_out_o : 1'b1;
    wire logic [3:0] sw = {phase_a_plus_output_o, phase_a_minus_output_o,
        phase_b_plus_output_o, phase_b_minus_output_o};
    int err_total = 0, samples_checked = 0;

    always #5 clk_i = ~clk_i;

    sbs_top dut (.*);
    sbs_host_model host (.clk_i, .step_clk_o(step_clk_i), .dir_o(dir_i),
        .brake_hold_o(brake_hold_i), .sel_o(step_resolution_select_i));

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic single cycle; no fixed latency assumed
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask

    // Angle advance per step by resolution code
    function automatic logic [6:0] inc_of(input logic [2:0] m);
        case (m)
            MODE_FULL: return INC_FULL;
            MODE_HALF_A, MODE_HALF_B: return INC_HALF;
            MODE_QUARTER: return INC_QUARTER;
            MODE_EIGHTH: return INC_EIGHTH;
            MODE_SIXTEENTH: return INC_SIXTEENTH;
            default: return INC_THIRTYSECOND;
        endcase
    endfunction

    // Held brake pattern from the angle at entry
    function automatic logic [3:0] brake_sw(input logic [6:0] a);
        return {a < 7'h40, a >= 7'h40, a[6] == a[5], a[6] != a[5]};
    endfunction

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    initial begin
        logic [2:0] m;
        int n;
        logic d, b;
        void'($urandom(38130));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        w(3);
        chk("home oe", home_angle_flag_oe_o, 1'b1);
        chk("home pin", home_angle_flag_i, 1'b0);
        // Standby and home set, fault and alarm pins pulled high
        wb(1'b0, REG_STATUS, 32'h0);
        chk("status", rd, 32'h00018c00);
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rd, 32'(CTRL_RESET));
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, REG_IRQ_EN, 32'hf);
        host.mode(MODE_FULL);
        // Four full steps wrap to home
        host.step(4, 1'b1);
        w(3);
        chk("wrap home", home_angle_flag_oe_o, 1'b1);
        m = MODE_FULL;
        b = 1'b0;
        for (int i = 0; i < 12; i++) begin
            m = 3'($urandom_range(7, 1));
            n = $urandom_range(9, 1);
            d = 1'($urandom);
            host.mode(m);
            if (!b)
                sign_ang = exp_ang;
            b = 1'($urandom);
            host.brake(b);
            host.step(n, d);
            exp_ang = d ? exp_ang + 7'(n) * inc_of(m) : exp_ang - 7'(n) * inc_of(m);
            w(3);
            chk("angle", angle_o, exp_ang);
            chk("home", home_angle_flag_oe_o, exp_ang == 7'h00);
            chk("forced", ratio_forced_o, b);
            chk("ratio", ratio_force_o, b ? RATIO_FULL : RATIO_ZERO);
            if (b)
                chk("brake sw", sw, brake_sw(sign_ang));
            else
                chk("run sw", sw, brake_sw(exp_ang));
        end
        host.brake(1'b1);
        cc_disable_i <= 1'b1;
        w(3);
        chk("all on", sw, 4'hf);
        // Output enable off drops all switches; software brake replaces the pin
        wb(1'b1, REG_CTRL, 32'h0);
        w(2);
        chk("sw off", sw, 4'h0);
        wb(1'b1, REG_CTRL, 32'h3);
        host.brake(1'b0);
        w(3);
        chk("soft brake", sw, 4'hf);
        cc_disable_i <= 1'b0;
        thermal_shutdown_i <= 1'b1;
        w(1);
        thermal_shutdown_i <= 1'b0;
        w(3);
        chk("fault pin", fault_flag_i, 1'b0);
        chk("trip sw", sw, 4'h0);
        chk("irq", irq_o, 1'b1);
        host.mode(MODE_LOW_POWER_STANDBY);
        w(4);
        chk("low_power_standby fault", fault_flag_oe_o, 1'b0);
        chk("low_power_standby angle", angle_o, 7'h00);
        host.mode(MODE_FULL);
        overcurrent_shutdown_i <= 1'b1;
        w(1);
        overcurrent_shutdown_i <= 1'b0;
        w(3);
        chk("oc fault", fault_flag_oe_o, 1'b1);
        motor_power_supply_i <= 1'b0;
        w(3);
        motor_power_supply_i <= 1'b1;
        w(3);
        chk("power fault", fault_flag_oe_o, 1'b0);
        wb(1'b1, REG_IRQ_CLR, 32'hf);
        w(2);
        chk("irq clr", irq_o, 1'b0);
        alarm_detect_i <= 1'b1;
        w(1);
        alarm_detect_i <= 1'b0;
        w(6);
        chk("alarm pin", thermal_alarm_out_i, 1'b0);
        alarm_release_i <= 1'b1;
        w(1);
        alarm_release_i <= 1'b0;
        w(3);
        chk("alarm off", thermal_alarm_out_oe_o, 1'b0);
        wb(1'b0, REG_IRQ_STAT, 32'h0);
        chk("alarm events", rd & 32'h6, 32'h6);
        complete_run();
    end
endmodule

bind sbs_top sbs_assertions chk_u (.*);
